// ==== src/sos_selector.sv ====
// Status output selector: routes driver status flags to output terminals by code
`timescale 1ns/1ps
`include "sos_defs.svh"
module sos_selector
  import sos_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  // Terminal code configuration
  input  wire logic                   cfg_wr,
  input  wire logic [`SOS_TERM_W-1:0] cfg_term,
  input  wire logic [`SOS_CODE_W-1:0] cfg_code,
  // User logic outputs zero and one
  input  wire logic [`SOS_CODE_W-1:0] usr0_src_a,
  input  wire logic [`SOS_CODE_W-1:0] usr0_src_b,
  input  wire logic                   usr0_use_or,
  input  wire logic [`SOS_CODE_W-1:0] usr1_src_a,
  input  wire logic [`SOS_CODE_W-1:0] usr1_src_b,
  input  wire logic                   usr1_use_or,
  // Status flags from the motion core
  input  wire logic                   motion_active,
  input  wire logic                   system_busy,
  input  wire logic                   excitable,
  input  wire logic                   positioning_done,
  input  wire logic                   cyclic_sync_position_mode,
  input  wire logic                   zero_speed,
  input  wire logic                   torque_limit_hit,
  input  wire logic                   speed_reached,
  input  wire logic                   excitation_monitor,
  input  wire logic                   homing_done,
  input  wire logic                   preset_done,
  input  wire logic                   preset_required,
  input  wire logic                   coord_lost,
  input  wire logic                   wrap_cross,
  input  wire logic                   forward_soft_limit,
  input  wire logic                   reverse_soft_limit,
  input  wire logic                   revolution_pulse,
  input  wire logic                   wrap_home,
  input  wire logic                   wrap_enable,
  input  wire logic [`SOS_AREA_W-1:0] window_in,
  input  wire logic                   main_power_on,
  input  wire logic                   brake_released,
  input  wire logic                   regen_state,
  input  wire logic                   torque_limiting_active,
  input  wire logic                   speed_limiting_active,
  input  wire logic                   pulse_generation_active,
  input  wire logic                   command_accept_ready,
  input  wire logic                   command_buffer_occupied,
  // Safety torque-off pins, high is ON
  input  wire logic                   safety_input_one,
  input  wire logic                   safety_input_two,
  // Output terminals
  output logic      [`SOS_NUM_OUT-1:0] term_out
);

  sos_state_t             s_r;
  sos_state_t             s_nxt;
  logic [`SOS_SAFE_W-1:0] safe_sync;
  logic                   any_safety_off;
  logic                   both_safety_off;
  logic [`SOS_FLAG_N-1:0] flag_vec;

  // AND or OR of two flags picked by code
  function automatic logic sos_user(input logic [`SOS_FLAG_N-1:0] fv,
                                    input logic [`SOS_CODE_W-1:0] a,
                                    input logic [`SOS_CODE_W-1:0] b,
                                    input logic                   use_or);
    logic fa;
    logic fb;
    fa = fv[a];
    fb = fv[b];
    return use_or ? (fa | fb) : (fa & fb);
  endfunction

  // Safety pins come from outside the clock domain
  sos_sync u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .pin_in   ({safety_input_two, safety_input_one}),
    .pin_sync (safe_sync)
  );

  // OFF means pin low
  assign any_safety_off  = ~&safe_sync;
  assign both_safety_off = ~|safe_sync;

  // Flag per code; unlisted codes stay zero, so code 0 and 128 read OFF
  always_comb begin
    flag_vec = '0;
    flag_vec[`SOS_CODE_MOVE]    = motion_active;
    flag_vec[`SOS_CODE_BUSY]    = system_busy;
    flag_vec[`SOS_CODE_TOREC]   = s_r.torque_off_recovery_monitor;
    flag_vec[`SOS_CODE_INPOS]   = positioning_done & ~cyclic_sync_position_mode;
    flag_vec[`SOS_CODE_ZSPD]    = zero_speed;
    flag_vec[`SOS_CODE_TLHIT]   = torque_limit_hit;
    flag_vec[`SOS_CODE_SPDOK]   = speed_reached & ~cyclic_sync_position_mode;
    flag_vec[`SOS_CODE_EXCIT]   = excitation_monitor;
    flag_vec[`SOS_CODE_HOMED]   = s_r.homed;
    flag_vec[`SOS_CODE_PRAGN]   = s_r.preset_needed_again;
    flag_vec[`SOS_CODE_WRTGL]   = s_r.wrap_overflow_toggle;
    flag_vec[`SOS_CODE_FWSL]    = forward_soft_limit;
    flag_vec[`SOS_CODE_RVSL]    = reverse_soft_limit;
    flag_vec[`SOS_CODE_REV]     = revolution_pulse;
    flag_vec[`SOS_CODE_WHOME]   = wrap_home & wrap_enable;
    flag_vec[`SOS_CODE_MPWR]    = main_power_on;
    flag_vec[`SOS_CODE_BRAKE]   = brake_released;
    flag_vec[`SOS_CODE_REGEN]   = regen_state;
    flag_vec[`SOS_CODE_BOTHOFF] = both_safety_off;
    flag_vec[`SOS_CODE_ANYOFF]  = any_safety_off;
    flag_vec[`SOS_CODE_TQLIM]   = torque_limiting_active;
    flag_vec[`SOS_CODE_SPLIM]   = speed_limiting_active;
    flag_vec[`SOS_CODE_PULSE]   = pulse_generation_active;
    flag_vec[`SOS_CODE_CMDRDY]  = command_accept_ready;
    flag_vec[`SOS_CODE_CMDFULL] = command_buffer_occupied;
    // Area windows sit on consecutive codes
    for (int k = 0; k < `SOS_AREA_W; k++) begin
      flag_vec[`SOS_CODE_WIN0 + k[`SOS_CODE_W-1:0]] = window_in[k];
    end
    // User outputs filled last; user 1 can source user 0, while user 0 reads user 1 as zero
    flag_vec[`SOS_CODE_USR0] = sos_user(flag_vec, usr0_src_a, usr0_src_b,
                                        usr0_use_or);
    flag_vec[`SOS_CODE_USR1] = sos_user(flag_vec, usr1_src_a, usr1_src_b,
                                        usr1_use_or);
  end

  // Next state: codes, sticky monitors, terminal outputs
  always_comb begin
    s_nxt = s_r;
    if (cfg_wr && (cfg_term < `SOS_TERM_W'(`SOS_NUM_OUT))) begin
      s_nxt.codes[cfg_term] = cfg_code;
    end
    // Set by any OFF, held until excitable; set wins over clear
    s_nxt.torque_off_recovery_monitor = any_safety_off |
      (s_r.torque_off_recovery_monitor & ~excitable);
    // Homed until coordinates are lost; completion wins
    s_nxt.homed = homing_done | preset_done | (s_r.homed & ~coord_lost);
    // Armed by a preset, disarmed once the motor moves
    s_nxt.preset_armed = preset_done | (s_r.preset_armed & ~motion_active);
    s_nxt.preset_needed_again = (preset_required & s_r.preset_armed) |
      (s_r.preset_needed_again & ~(preset_done | motion_active));
    // Level flips per crossing instead of a pulse
    s_nxt.wrap_overflow_toggle = s_r.wrap_overflow_toggle ^ wrap_cross;
    // Registered selection keeps terminal pins glitch free
    for (int i = 0; i < `SOS_NUM_OUT; i++) begin
      s_nxt.term_out[i] = flag_vec[s_r.codes[i]];
    end
  end

  // Single state register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r <= '{codes: {`SOS_RST_CODE5, `SOS_RST_CODE4, `SOS_RST_CODE3,
                       `SOS_RST_CODE2, `SOS_RST_CODE1, `SOS_RST_CODE0},
               default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign term_out = s_r.term_out;

  // Checks watch terminals one and two; every terminal routes the same way
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_move;
    (s_r.codes[2] == `SOS_CODE_MOVE) |=> (term_out[2] == $past(motion_active));
  endproperty
  a_move: assert property (p_move) else $error("move output mismatch");

  property p_off;
    (s_r.codes[2] == `SOS_CODE_OFF) || (s_r.codes[2] == `SOS_CODE_NONE) |=> !term_out[2];
  endproperty
  a_off: assert property (p_off) else $error("unused or off terminal driven");

  property p_inpos_csp;
    (s_r.codes[2] == `SOS_CODE_INPOS) && cyclic_sync_position_mode |=> !term_out[2];
  endproperty
  a_inpos_csp: assert property (p_inpos_csp) else $error("in-pos in csp mode");

  property p_spd_csp;
    (s_r.codes[2] == `SOS_CODE_SPDOK) && cyclic_sync_position_mode |=> !term_out[2];
  endproperty
  a_spd_csp: assert property (p_spd_csp) else $error("speed reached in csp mode");

  property p_torec_hold;
    s_r.torque_off_recovery_monitor && !excitable |=> s_r.torque_off_recovery_monitor;
  endproperty
  a_torec_hold: assert property (p_torec_hold) else $error("recovery monitor dropped");

  property p_torec_set;
    !safety_input_one ##1 !safety_input_one ##1 !safety_input_one
      |=> s_r.torque_off_recovery_monitor;
  endproperty
  a_torec_set: assert property (p_torec_set) else $error("recovery monitor not set");

  property p_wrap_tgl;
    wrap_cross |=> (s_r.wrap_overflow_toggle != $past(s_r.wrap_overflow_toggle));
  endproperty
  a_wrap_tgl: assert property (p_wrap_tgl) else $error("wrap toggle missed");

  property p_wrap_still;
    !wrap_cross |=> $stable(s_r.wrap_overflow_toggle);
  endproperty
  a_wrap_still: assert property (p_wrap_still) else $error("wrap toggle spurious");

  property p_whome;
    (s_r.codes[2] == `SOS_CODE_WHOME) && !wrap_enable |=> !term_out[2];
  endproperty
  a_whome: assert property (p_whome) else $error("wrap home without enable");

  property p_both;
    (s_r.codes[1] == `SOS_CODE_BOTHOFF) |=> (term_out[1] == $past(~|safe_sync));
  endproperty
  a_both: assert property (p_both) else $error("both-off mismatch");

  property p_any;
    (s_r.codes[2] == `SOS_CODE_ANYOFF) |=> (term_out[2] == $past(~&safe_sync));
  endproperty
  a_any: assert property (p_any) else $error("any-off mismatch");

  property p_homed;
    homing_done || preset_done |=> s_r.homed;
  endproperty
  a_homed: assert property (p_homed) else $error("homed not set");

  property p_cfg;
    cfg_wr && (cfg_term == `SOS_TERM_W'(2)) |=> (s_r.codes[2] == $past(cfg_code));
  endproperty
  a_cfg: assert property (p_cfg) else $error("code write lost");

  property p_area;
    (s_r.codes[2] == `SOS_CODE_WIN0) |=> (term_out[2] == $past(window_in[0]));
  endproperty
  a_area: assert property (p_area) else $error("area window mismatch");

  property p_busy;
    (s_r.codes[2] == `SOS_CODE_BUSY) |=> (term_out[2] == $past(system_busy));
  endproperty
  a_busy: assert property (p_busy) else $error("busy output mismatch");

  property p_zspd;
    (s_r.codes[2] == `SOS_CODE_ZSPD) |=> (term_out[2] == $past(zero_speed));
  endproperty
  a_zspd: assert property (p_zspd) else $error("zero speed mismatch");

  property p_tlhit;
    (s_r.codes[2] == `SOS_CODE_TLHIT) |=> (term_out[2] == $past(torque_limit_hit));
  endproperty
  a_tlhit: assert property (p_tlhit) else $error("torque limit hit mismatch");

  property p_excit;
    (s_r.codes[2] == `SOS_CODE_EXCIT) |=> (term_out[2] == $past(excitation_monitor));
  endproperty
  a_excit: assert property (p_excit) else $error("excitation mismatch");

  // Armed preset plus a new request must raise the flag
  property p_again;
    preset_required && s_r.preset_armed |=> s_r.preset_needed_again;
  endproperty
  a_again: assert property (p_again) else $error("preset again not set");

  property p_again_clr;
    motion_active && !preset_required |=> !s_r.preset_needed_again;
  endproperty
  a_again_clr: assert property (p_again_clr) else $error("preset again stuck");

  property p_soft;
    (s_r.codes[2] == `SOS_CODE_FWSL) |=> (term_out[2] == $past(forward_soft_limit));
  endproperty
  a_soft: assert property (p_soft) else $error("soft limit mismatch");

  property p_rev;
    (s_r.codes[2] == `SOS_CODE_REV) |=> (term_out[2] == $past(revolution_pulse));
  endproperty
  a_rev: assert property (p_rev) else $error("revolution output mismatch");

  property p_power;
    (s_r.codes[2] == `SOS_CODE_MPWR) |=> (term_out[2] == $past(main_power_on));
  endproperty
  a_power: assert property (p_power) else $error("main power mismatch");

  // OR mode with source a high must drive the terminal high
  property p_user_or;
    (s_r.codes[1] == `SOS_CODE_USR0) && usr0_use_or && flag_vec[usr0_src_a] |=> term_out[1];
  endproperty
  a_user_or: assert property (p_user_or) else $error("user OR output low");

  property p_tqlim;
    (s_r.codes[2] == `SOS_CODE_TQLIM) |=> (term_out[2] == $past(torque_limiting_active));
  endproperty
  a_tqlim: assert property (p_tqlim) else $error("torque limiting mismatch");

  property p_pulse;
    (s_r.codes[2] == `SOS_CODE_PULSE) |=> (term_out[2] == $past(pulse_generation_active));
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse generation mismatch");

  property p_cmdrdy;
    (s_r.codes[2] == `SOS_CODE_CMDRDY) |=> (term_out[2] == $past(command_accept_ready));
  endproperty
  a_cmdrdy: assert property (p_cmdrdy) else $error("accept ready mismatch");

  property p_cmdfull;
    (s_r.codes[2] == `SOS_CODE_CMDFULL) |=> (term_out[2] == $past(command_buffer_occupied));
  endproperty
  a_cmdfull: assert property (p_cmdfull) else $error("buffer occupied mismatch");

  // Lost coordinates clear the home flag unless completion comes at once
  property p_homed_clr;
    coord_lost && !homing_done && !preset_done |=> !s_r.homed;
  endproperty
  a_homed_clr: assert property (p_homed_clr) else $error("homed not cleared");

  property p_torec_clr;
    excitable && !any_safety_off |=> !s_r.torque_off_recovery_monitor;
  endproperty
  a_torec_clr: assert property (p_torec_clr) else $error("recovery monitor stuck");

  // Main scenarios
  c_toggle: cover property (s_r.wrap_overflow_toggle ##1 !s_r.wrap_overflow_toggle);
  c_torec:  cover property (s_r.torque_off_recovery_monitor ##1
                            !s_r.torque_off_recovery_monitor);
  c_again:  cover property (s_r.preset_needed_again);
  c_user:   cover property (s_r.codes[1] == `SOS_CODE_USR0 ##1 term_out[1]);

endmodule

// ==== src/sos_defs.svh ====
// Constants for the status output selector: widths, assignment codes, reset codes
`ifndef SOS_DEFS_SVH
`define SOS_DEFS_SVH

// Terminal count and code width
`define SOS_NUM_OUT       6
`define SOS_CODE_W        8
`define SOS_TERM_W        3
`define SOS_SAFE_W        2
`define SOS_AREA_W        8
`define SOS_FLAG_N        256

// Assignment codes
`define SOS_CODE_NONE     8'h00
`define SOS_CODE_OFF      8'h80
`define SOS_CODE_MOVE     8'h86
`define SOS_CODE_BUSY     8'h88
`define SOS_CODE_TOREC    8'h89
`define SOS_CODE_INPOS    8'h8a
`define SOS_CODE_ZSPD     8'h8b
`define SOS_CODE_TLHIT    8'h8c
`define SOS_CODE_SPDOK    8'h8d
`define SOS_CODE_EXCIT    8'h8e
`define SOS_CODE_HOMED    8'h90
`define SOS_CODE_PRAGN    8'h95
`define SOS_CODE_WRTGL    8'h98
`define SOS_CODE_FWSL     8'h99
`define SOS_CODE_RVSL     8'h9a
`define SOS_CODE_REV      8'h9b
`define SOS_CODE_WHOME    8'h9c
`define SOS_CODE_WIN0     8'ha0
`define SOS_CODE_MPWR     8'ha8
`define SOS_CODE_BRAKE    8'ha9
`define SOS_CODE_REGEN    8'haa
`define SOS_CODE_BOTHOFF  8'hac
`define SOS_CODE_ANYOFF   8'had
`define SOS_CODE_USR0     8'hb4
`define SOS_CODE_USR1     8'hb5
`define SOS_CODE_TQLIM    8'hc0
`define SOS_CODE_SPLIM    8'hc1
`define SOS_CODE_PULSE    8'hc4
`define SOS_CODE_CMDRDY   8'hcc
`define SOS_CODE_CMDFULL  8'hcd

// Terminal codes after reset
`define SOS_RST_CODE0     8'h90
`define SOS_RST_CODE1     8'h89
`define SOS_RST_CODE2     8'h00
`define SOS_RST_CODE3     8'h8e
`define SOS_RST_CODE4     8'h86
`define SOS_RST_CODE5     8'h82

`endif

// ==== src/sos_pkg.sv ====
// Types shared by the status output selector modules
package sos_pkg;
  `include "sos_defs.svh"

  // Complete state of the selector
  typedef struct packed {
    logic [`SOS_NUM_OUT-1:0][`SOS_CODE_W-1:0] codes;
    logic                                     torque_off_recovery_monitor;
    logic                                     homed;
    logic                                     preset_armed;
    logic                                     preset_needed_again;
    logic                                     wrap_overflow_toggle;
    logic [`SOS_NUM_OUT-1:0]                  term_out;
  } sos_state_t;

  // Complete state of the two-stage synchroniser
  typedef struct packed {
    logic [`SOS_SAFE_W-1:0] meta;
    logic [`SOS_SAFE_W-1:0] stable;
  } sos_sync_t;
endpackage

// ==== src/sos_sync.sv ====
// Two-flop synchroniser for the safety torque-off pins
`timescale 1ns/1ps
`include "sos_defs.svh"
module sos_sync
  import sos_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic [`SOS_SAFE_W-1:0] pin_in,
  output logic      [`SOS_SAFE_W-1:0] pin_sync
);

  sos_sync_t s_r;
  sos_sync_t s_nxt;

  // First stage feeds only the second stage
  always_comb begin
    s_nxt        = s_r;
    s_nxt.meta   = pin_in;
    s_nxt.stable = s_r.meta;
  end

  // Reset to ON so a power-up does not flag a false OFF
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r <= '{meta: '1, stable: '1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pin_sync = s_r.stable;

endmodule

// ==== test/sos_core_model.sv ====
// Motion core stand-in: turns bench flag vectors into the selector's status inputs
`timescale 1ns/1ps
module sos_core_model (
  input  wire logic [31:0] lv,
  input  wire logic [4:0]  ev,
  input  wire logic [1:0]  safe,
  output logic             motion_active,
  output logic             system_busy,
  output logic             positioning_done,
  output logic             zero_speed,
  output logic             torque_limit_hit,
  output logic             speed_reached,
  output logic             excitation_monitor,
  output logic             forward_soft_limit,
  output logic             reverse_soft_limit,
  output logic             revolution_pulse,
  output logic             main_power_on,
  output logic             brake_released,
  output logic             regen_state,
  output logic             torque_limiting_active,
  output logic             speed_limiting_active,
  output logic             pulse_generation_active,
  output logic             command_accept_ready,
  output logic             command_buffer_occupied,
  output logic [7:0]       window_in,
  output logic             wrap_home,
  output logic             wrap_enable,
  output logic             excitable,
  output logic             cyclic_sync_position_mode,
  output logic             homing_done,
  output logic             preset_done,
  output logic             preset_required,
  output logic             coord_lost,
  output logic             wrap_cross,
  output logic             safety_input_one,
  output logic             safety_input_two
);
  // Level flags by bit position, matching the bench code table
  assign {speed_reached, torque_limit_hit, zero_speed, positioning_done,
          system_busy, motion_active} = lv[5:0];
  assign {revolution_pulse, reverse_soft_limit, forward_soft_limit,
          excitation_monitor} = lv[9:6];
  assign {pulse_generation_active, speed_limiting_active, torque_limiting_active,
          regen_state, brake_released, main_power_on} = lv[15:10];
  assign {command_buffer_occupied, command_accept_ready} = lv[17:16];
  assign window_in = lv[25:18];
  assign {cyclic_sync_position_mode, excitable, wrap_enable, wrap_home} = lv[29:26];
  // One-cycle event pulses
  assign {wrap_cross, coord_lost, preset_required, preset_done, homing_done} = ev;
  // Safety pins, high is ON; asynchronous to the core in the real part
  assign {safety_input_two, safety_input_one} = safe;
endmodule

// ==== test/status_output_selector_tb_top.sv ====
// Self-checking bench for the status output selector
`timescale 1ns/1ps
`include "sos_defs.svh"
module status_output_selector_tb_top;
  import sos_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cfg_wr = 1'b0;
  logic [2:0]  cfg_term = 3'h0;
  logic [7:0]  cfg_code = 8'h00;
  logic [7:0]  ua = 8'h86, ub = 8'h88, va = 8'h86, vb = 8'h88;
  logic        uor = 1'b0, vor = 1'b1;
  logic [31:0] lv = 32'h0;
  logic [4:0]  ev = 5'h0;
  logic [1:0]  safe = 2'h3;
  logic [5:0]  term_out;
  logic [7:0]  lc [18];
  int          fails = 0;
  int          checked = 0;
  int          cyc = 0;
  wire         f0, f1, f2, f3, f4, f5, f6, f7, f8, f9, f10, f11, f12, f13, f14, f15;
  wire         f16, f17, f18, f19, f20, f21, f22, f23, f24, f25, f26, f27, f28;
  wire [7:0]   win;

  always #12.5 sys_clk = ~sys_clk;

  sos_core_model u_sos_core_model (.lv(lv), .ev(ev), .safe(safe),
    .motion_active(f0), .system_busy(f1), .positioning_done(f2), .zero_speed(f3),
    .torque_limit_hit(f4), .speed_reached(f5), .excitation_monitor(f6),
    .forward_soft_limit(f7), .reverse_soft_limit(f8), .revolution_pulse(f9),
    .main_power_on(f10), .brake_released(f11), .regen_state(f12),
    .torque_limiting_active(f13), .speed_limiting_active(f14),
    .pulse_generation_active(f15), .command_accept_ready(f16),
    .command_buffer_occupied(f17), .window_in(win), .wrap_home(f18),
    .wrap_enable(f19), .excitable(f20), .cyclic_sync_position_mode(f21),
    .homing_done(f22), .preset_done(f23), .preset_required(f24), .coord_lost(f25),
    .wrap_cross(f26), .safety_input_one(f27), .safety_input_two(f28));

  sos_selector u_sos_selector (.sys_clk(sys_clk), .rst(rst), .cfg_wr(cfg_wr),
    .cfg_term(cfg_term), .cfg_code(cfg_code), .usr0_src_a(ua), .usr0_src_b(ub),
    .usr0_use_or(uor), .usr1_src_a(va), .usr1_src_b(vb), .usr1_use_or(vor),
    .motion_active(f0), .system_busy(f1), .excitable(f20), .positioning_done(f2),
    .cyclic_sync_position_mode(f21), .zero_speed(f3), .torque_limit_hit(f4),
    .speed_reached(f5), .excitation_monitor(f6), .homing_done(f22),
    .preset_done(f23), .preset_required(f24), .coord_lost(f25), .wrap_cross(f26),
    .forward_soft_limit(f7), .reverse_soft_limit(f8), .revolution_pulse(f9),
    .wrap_home(f18), .wrap_enable(f19), .window_in(win), .main_power_on(f10),
    .brake_released(f11), .regen_state(f12), .torque_limiting_active(f13),
    .speed_limiting_active(f14), .pulse_generation_active(f15),
    .command_accept_ready(f16), .command_buffer_occupied(f17),
    .safety_input_one(f27), .safety_input_two(f28), .term_out(term_out));

  // Verdict and end of run, reached from the main sequence or the watchdog
  task wrap_up();
    if (fails == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Compare one terminal bit
  task chk(input logic e, input logic g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // Wait n edges, then sample once updates have landed
  task settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // One-cycle code write strobe
  task wr(input logic [2:0] t, input logic [7:0] c);
    @(posedge sys_clk);
    cfg_wr <= 1'b1;
    cfg_term <= t;
    cfg_code <= c;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
  endtask

  task set_lv(input logic [31:0] v);
    @(posedge sys_clk);
    lv <= v;
  endtask

  task set_safe(input logic [1:0] s);
    @(posedge sys_clk);
    safe <= s;
  endtask

  // Single event pulse; fixed gap keeps strobes one cycle wide
  task pulse(input logic [4:0] m);
    @(posedge sys_clk);
    ev <= m;
    @(posedge sys_clk);
    ev <= 5'h0;
  endtask

  // Watchdog; the sequence itself uses only fixed waits
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      fails++;
      wrap_up();
    end
  end

  initial begin
    lc = '{8'h86, 8'h88, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'h99, 8'h9a,
           8'h9b, 8'ha8, 8'ha9, 8'haa, 8'hc0, 8'hc1, 8'hc4, 8'hcc, 8'hcd};
    settle(4);
    chk(1'b0, |term_out);
    @(posedge sys_clk);
    rst <= 1'b0;
    // Reset codes: 144 on 0, 142 on 3, 134 on 4, 130 unsupported on 5
    pulse(5'h01);
    set_lv(32'h41);
    settle(2);
    chk(1'b1, term_out[0]);
    chk(1'b1, term_out[3]);
    chk(1'b1, term_out[4]);
    chk(1'b0, term_out[5]);
    // Terminal 6 does not exist; writes to it must not disturb terminals 0 and 4
    wr(3'h6, 8'h80);
    settle(2);
    chk(1'b1, term_out[4]);
    chk(1'b1, term_out[0]);
    // Every plain level code, low then high, back to back on terminal 2
    for (int i = 0; i < 18; i++) begin
      wr(3'h2, lc[i]);
      set_lv(32'h0);
      settle(2);
      chk(1'b0, term_out[2]);
      set_lv(32'h1 << i);
      settle(2);
      chk(1'b1, term_out[2]);
    end
    // Area windows: only the matching window raises the output
    for (int k = 0; k < 8; k++) begin
      wr(3'h2, 8'ha0 + 8'(k));
      set_lv(32'h3fc0000 & ~(32'h1 << (18 + k)));
      settle(2);
      chk(1'b0, term_out[2]);
      set_lv(32'h1 << (18 + k));
      settle(2);
      chk(1'b1, term_out[2]);
    end
    // Cyclic sync position mode masks in-position and speed-reached
    wr(3'h2, 8'h8a);
    set_lv(32'h20000024);
    settle(2);
    chk(1'b0, term_out[2]);
    wr(3'h2, 8'h8d);
    settle(2);
    chk(1'b0, term_out[2]);
    // Wrap home needs the wrap setting enabled
    wr(3'h2, 8'h9c);
    set_lv(32'h4000000);
    settle(2);
    chk(1'b0, term_out[2]);
    set_lv(32'hc000000);
    settle(2);
    chk(1'b1, term_out[2]);
    // Unused and constant-off codes stay low with level bits 0 to 25 high
    wr(3'h2, 8'h00);
    set_lv(32'h3ffffff);
    settle(2);
    chk(1'b0, term_out[2]);
    wr(3'h2, 8'h80);
    settle(2);
    chk(1'b0, term_out[2]);
    // Safety monitors with the synchroniser in the path
    set_lv(32'h0);
    wr(3'h1, 8'hac);
    wr(3'h2, 8'had);
    wr(3'h3, 8'h89);
    set_safe(2'h2);
    settle(4);
    chk(1'b0, term_out[1]);
    chk(1'b1, term_out[2]);
    chk(1'b1, term_out[3]);
    set_safe(2'h0);
    settle(4);
    chk(1'b1, term_out[1]);
    set_safe(2'h3);
    settle(4);
    chk(1'b0, term_out[2]);
    chk(1'b1, term_out[3]);
    set_lv(32'h10000000);
    settle(2);
    chk(1'b0, term_out[3]);
    // Home-end cleared by lost coordinates, set again by preset
    pulse(5'h08);
    settle(1);
    chk(1'b0, term_out[0]);
    pulse(5'h02);
    settle(1);
    chk(1'b1, term_out[0]);
    // Preset needed again: armed by preset, cleared by motion
    wr(3'h2, 8'h95);
    pulse(5'h04);
    settle(1);
    chk(1'b1, term_out[2]);
    set_lv(32'h1);
    settle(2);
    chk(1'b0, term_out[2]);
    // Wrap overflow toggles on each crossing
    wr(3'h2, 8'h98);
    set_lv(32'h0);
    settle(2);
    chk(1'b0, term_out[2]);
    pulse(5'h10);
    settle(2);
    chk(1'b1, term_out[2]);
    pulse(5'h10);
    settle(2);
    chk(1'b0, term_out[2]);
    // User outputs: AND on 180, OR on 181, sources motion and busy
    wr(3'h1, 8'hb4);
    wr(3'h2, 8'hb5);
    set_lv(32'h1);
    settle(2);
    chk(1'b0, term_out[1]);
    chk(1'b1, term_out[2]);
    set_lv(32'h3);
    settle(2);
    chk(1'b1, term_out[1]);
    // Swapped modes: OR on 180, AND on 181
    @(posedge sys_clk);
    uor <= 1'b1;
    vor <= 1'b0;
    set_lv(32'h1);
    settle(2);
    chk(1'b1, term_out[1]);
    chk(1'b0, term_out[2]);
    // Mid-run reset brings back the reset codes and clears the monitors
    @(posedge sys_clk);
    rst <= 1'b1;
    settle(2);
    chk(1'b0, |term_out);
    @(posedge sys_clk);
    rst <= 1'b0;
    set_safe(2'h1);
    settle(4);
    chk(1'b1, term_out[1]);
    chk(1'b0, term_out[2]);
    chk(1'b0, term_out[0]);
    chk(1'b1, term_out[4]);
    wrap_up();
  end
endmodule
